// *** pkg/pdm_pkg.sv ***
package pdm_pkg;
  // Register map
  localparam logic [31:0] PDM_STBY_CTRL_ADDR = 32'hffff8614;
  localparam logic [7:0] PDM_STBY_CTRL_RESET = 8'h1f;
  localparam int PDM_DEEP_STOP_BIT = 7;
  localparam int PDM_PORT_FLOAT_BIT = 6;
  localparam logic [7:0] PDM_RSVD_READ = 8'h1f;
  localparam logic [7:0] PDM_UNMAPPED_READ = 8'h00;
  // Interrupt priority field
  localparam int PDM_PRIO_W = 4;
  // Power mode of the block
  typedef enum logic [1:0] {
    PDM_RUN,
    PDM_SLEEP,
    PDM_STANDBY
  } pdm_mode_t;
endpackage

// *** src/pdm_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
// Two-flop synchroniser for pin levels; reset value chosen by parameter
module pdm_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic d,
  output logic q
);
  logic meta_ff;
  logic q_ff;
  logic nxt_meta;
  logic nxt_q;

  // First stage feeds only the second stage
  always_comb begin
    nxt_meta = clk_en ? d : meta_ff;
    nxt_q = clk_en ? meta_ff : q_ff;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_ff <= RST_VAL;
      q_ff <= RST_VAL;
    end else begin
      meta_ff <= nxt_meta;
      q_ff <= nxt_q;
    end
  end

  assign q = q_ff;
endmodule
`default_nettype wire

// *** src/pdm_power_down_ctrl.sv ***
//Contract
//RULE_01 - Sleep instruction, deep_stop clear: sleep mode
//RULE_02 - Sleep instruction, deep_stop set: standby mode
//RULE_03 - Sleep keeps clock and peripherals running
//RULE_04 - CPU halts at once, registers retained
//RULE_05 - Standby halts clock, CPU, peripherals
//RULE_06 - deep_stop set refused while watchdog runs
//RULE_07 - Software stops watchdog before requesting standby
//RULE_08 - Standby ports hold or float per select
//RULE_09 - port_float set refused while watchdog runs
//RULE_10 - Reset loads control register with 1f
//RULE_11 - Bit5 reads 0, bits4-0 read 1
//RULE_12 - Accepted interrupt ends sleep, starts exception
//RULE_13 - Masked or disabled interrupt keeps sleep
//RULE_14 - Transfer address error ends sleep
//RULE_15 - Power-on reset ends sleep
//RULE_16 - Manual reset ends sleep
//RULE_17 - Only power-on reset leaves standby
//RULE_18 - Standby entry initialises chosen peripheral registers
`timescale 1ns/1ns
`default_nettype none
module pdm_power_down_ctrl
  import pdm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Register port
  input wire logic [31:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // CPU and watchdog side, same clock
  input wire logic sleep_exec,
  input wire logic watchdog_run_enable,
  input wire logic irq_pending,
  input wire logic irq_src_enabled,
  input wire logic [3:0] irq_level,
  input wire logic [3:0] cpu_mask_level,
  input wire logic xfer_addr_err,
  // Reset pins, asynchronous to the clock
  input wire logic power_on_reset_n,
  input wire logic manual_reset_n,
  // Status and controls
  output logic cpu_halt,
  output logic periph_clk_en,
  output logic sys_clk_run,
  output logic irq_exc_start,
  output logic addr_err_exc_start,
  output logic manual_reset_req,
  output logic periph_standby_init,
  output logic port_hold,
  output logic port_float,
  output logic [1:0] pd_mode
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic por_n_s;
  logic manual_reset_n_n_s;

  // Reset pins are asynchronous; two flops before any logic reads them.
  // Both idle high, so the flops reset high and no false reset follows rst
  pdm_sync #(.RST_VAL(1'b1)) u_sync_por (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .d(power_on_reset_n),
    .q(por_n_s)
  );

  pdm_sync #(.RST_VAL(1'b1)) u_sync_manual_reset_n (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .d(manual_reset_n),
    .q(manual_reset_n_n_s)
  );

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  logic deep_stop_ff;
  logic port_float_ff;
  logic nxt_deep_stop;
  logic nxt_port_float;
  logic ctrl_hit;
  logic ctrl_wr;
  logic por_active;

  // Full 32-bit compare; any other address reads as zero
  assign ctrl_hit = (reg_addr == PDM_STBY_CTRL_ADDR);
  assign ctrl_wr = reg_wr && ctrl_hit;
  // Synchronised pin; reloads the control bits while low
  assign por_active = !por_n_s;

  // Next value of the two writable bits
  always_comb begin
    nxt_deep_stop = deep_stop_ff;
    nxt_port_float = port_float_ff;
    if (por_active) begin
      // RULE_10 reset initial value
      nxt_deep_stop = PDM_STBY_CTRL_RESET[PDM_DEEP_STOP_BIT];
      nxt_port_float = PDM_STBY_CTRL_RESET[PDM_PORT_FLOAT_BIT];
    end else if (ctrl_wr) begin
      // Clearing is always allowed, so software can back out
      // RULE_06 watchdog blocks deep stop
      if (!reg_wdata[PDM_DEEP_STOP_BIT] || !watchdog_run_enable) begin
        nxt_deep_stop = reg_wdata[PDM_DEEP_STOP_BIT];
      end
      // RULE_09 watchdog blocks float select
      if (!reg_wdata[PDM_PORT_FLOAT_BIT] || !watchdog_run_enable) begin
        nxt_port_float = reg_wdata[PDM_PORT_FLOAT_BIT];
      end
    end
  end

  // Writable bits only; the reserved bits are not stored at all
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      deep_stop_ff <= PDM_STBY_CTRL_RESET[PDM_DEEP_STOP_BIT];
      port_float_ff <= PDM_STBY_CTRL_RESET[PDM_PORT_FLOAT_BIT];
    end else if (clk_en) begin
      deep_stop_ff <= nxt_deep_stop;
      port_float_ff <= nxt_port_float;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic ctrl_rd;

  // A read is only answered on an enabled edge
  assign ctrl_rd = reg_rd && ctrl_hit && clk_en;

  // Data stand for one cycle and are zero otherwise, so a stale
  // value is never taken for a fresh answer
  always_comb begin
    nxt_rdata = PDM_UNMAPPED_READ;
    if (ctrl_rd) begin
      // RULE_11 reserved bits fixed on read, writes ignored
      nxt_rdata = PDM_RSVD_READ;
      nxt_rdata[PDM_DEEP_STOP_BIT] = deep_stop_ff;
      nxt_rdata[PDM_PORT_FLOAT_BIT] = port_float_ff;
    end
  end

  // No enable here: a frozen clock drops the data to zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= PDM_UNMAPPED_READ;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // ----------------------------------------
  // Power mode machine
  // ----------------------------------------
  pdm_mode_t mode_ff;
  pdm_mode_t nxt_mode;
  logic irq_exc_ff;
  logic nxt_irq_exc;
  logic aerr_exc_ff;
  logic nxt_aerr_exc;
  logic manual_reset_n_ff;
  logic nxt_manual_reset_n;
  logic sby_init_ff;
  logic nxt_sby_init;
  logic irq_accept;

  // Equal priority is not enough: the mask level itself still blocks
  // RULE_13 priority must exceed mask and source be enabled
  assign irq_accept = irq_pending && irq_src_enabled && (irq_level > cpu_mask_level);

  // Next mode; exception pulses default low so each lasts one cycle
  always_comb begin
    nxt_mode = mode_ff;
    nxt_irq_exc = 1'b0;
    nxt_aerr_exc = 1'b0;
    nxt_manual_reset_n = 1'b0;
    nxt_sby_init = 1'b0;
    case (mode_ff)
      PDM_RUN: begin
        if (por_active) begin
          // Sleep instruction is ignored while power-on reset is held
          nxt_mode = PDM_RUN;
        end else if (sleep_exec && deep_stop_ff) begin
          // The bit can only have been set with the watchdog stopped
          // RULE_02 standby entry
          nxt_mode = PDM_STANDBY;
          // RULE_18 one pulse to reset chosen peripheral registers
          nxt_sby_init = 1'b1;
        end else if (sleep_exec) begin
          // RULE_01 sleep entry
          nxt_mode = PDM_SLEEP;
        end
        // Manual reset counts only while power-on reset is inactive
        nxt_manual_reset_n = !manual_reset_n_n_s && !por_active;
      end
      PDM_SLEEP: begin
        // Resets take precedence over exception wakeups
        if (por_active) begin
          // RULE_15 power-on reset ends sleep
          nxt_mode = PDM_RUN;
        end else if (!manual_reset_n_n_s) begin
          // RULE_16 manual reset ends sleep
          nxt_mode = PDM_RUN;
          nxt_manual_reset_n = 1'b1;
        end else if (xfer_addr_err) begin
          // RULE_14 address error wakeup
          nxt_mode = PDM_RUN;
          nxt_aerr_exc = 1'b1;
        end else if (irq_accept) begin
          // RULE_12 interrupt wakeup
          nxt_mode = PDM_RUN;
          nxt_irq_exc = 1'b1;
        end else begin
          // RULE_13 masked interrupt keeps sleep
          nxt_mode = PDM_SLEEP;
        end
      end
      PDM_STANDBY: begin
        // Manual reset, interrupts and address errors are ignored here
        // RULE_17 only power-on reset leaves standby
        if (por_active) begin
          nxt_mode = PDM_RUN;
        end
      end
      default: begin
        // Unused code falls back to run
        nxt_mode = PDM_RUN;
      end
    endcase
  end

  // Mode and pulses; frozen with the clock enable
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode_ff <= PDM_RUN;
      irq_exc_ff <= 1'b0;
      aerr_exc_ff <= 1'b0;
      manual_reset_n_ff <= 1'b0;
      sby_init_ff <= 1'b0;
    end else if (clk_en) begin
      mode_ff <= nxt_mode;
      irq_exc_ff <= nxt_irq_exc;
      aerr_exc_ff <= nxt_aerr_exc;
      manual_reset_n_ff <= nxt_manual_reset_n;
      sby_init_ff <= nxt_sby_init;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // RULE_04 halt follows the mode register directly, no pipeline
  assign cpu_halt = (mode_ff != PDM_RUN);
  // RULE_03 clock stays up in sleep
  assign sys_clk_run = (mode_ff != PDM_STANDBY);
  // RULE_05 standby stops peripherals and clock
  assign periph_clk_en = (mode_ff != PDM_STANDBY);
  // RULE_08 ports hold or float only in standby
  assign port_hold = (mode_ff == PDM_STANDBY) && !port_float_ff;
  assign port_float = (mode_ff == PDM_STANDBY) && port_float_ff;

  // Registered pulses to the core, one cycle each while enabled
  assign irq_exc_start = irq_exc_ff;
  assign addr_err_exc_start = aerr_exc_ff;
  // Level while the pin is low in run mode, so the core sees it settle
  assign manual_reset_req = manual_reset_n_ff;

  // RULE_18 peripherals reset chosen registers
  assign periph_standby_init = sby_init_ff;

  // Mode code for status; follows the mode register directly
  assign pd_mode = mode_ff;

endmodule
`default_nettype wire

// *** tb/pdm_power_down_ctrl_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none
// --------------------------------
// Port checker for the mode control
// --------------------------------
module pdm_power_down_ctrl_assertions
  import pdm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [31:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic sleep_exec,
  input wire logic irq_pending,
  input wire logic irq_src_enabled,
  input wire logic [3:0] irq_level,
  input wire logic [3:0] cpu_mask_level,
  input wire logic xfer_addr_err,
  input wire logic power_on_reset_n,
  input wire logic cpu_halt,
  input wire logic periph_clk_en,
  input wire logic sys_clk_run,
  input wire logic irq_exc_start,
  input wire logic port_hold,
  input wire logic port_float,
  input wire logic [1:0] pd_mode
);
  // One domain, so clock and reset are given once
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_SLEEP_RUN: assert property (pd_mode == PDM_SLEEP |-> sys_clk_run && periph_clk_en && cpu_halt)
    else $error("sleep stops clocks");
  AST_STBY_CLK: assert property (pd_mode == PDM_STANDBY |-> !sys_clk_run && !periph_clk_en)
    else $error("clocks run in standby");
  AST_HALT_CAUSE: assert property ($rose(cpu_halt) |-> $past(sleep_exec))
    else $error("halt without sleep");
  AST_IRQ_WAKE: assert property (pd_mode == PDM_SLEEP && clk_en && irq_pending && irq_src_enabled
    && irq_level > cpu_mask_level |=> pd_mode == PDM_RUN)
    else $error("accepted irq kept sleep");
  AST_ERR_WAKE: assert property (pd_mode == PDM_SLEEP && clk_en && xfer_addr_err |=> pd_mode == PDM_RUN)
    else $error("address error kept sleep");
  AST_EXC_PULSE: assert property (irq_exc_start |-> $past(pd_mode) == PDM_SLEEP ##1 !irq_exc_start)
    else $error("bad irq exception pulse");
  AST_PORT: assert property (port_hold || port_float |-> pd_mode == PDM_STANDBY && port_hold != port_float)
    else $error("bad port state");
  AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read");
  AST_RSVD: assert property (reg_rd && clk_en && reg_addr == PDM_STBY_CTRL_ADDR |=> reg_rdata[5:0] == 6'h1f)
    else $error("reserved bits wrong");
  AST_STBY_EXIT: assert property ($fell(pd_mode == PDM_STANDBY) |-> !$past(power_on_reset_n, 3))
    else $error("standby left without power-on");
endmodule
bind pdm_power_down_ctrl pdm_power_down_ctrl_assertions pdm_power_down_ctrl_assertions_i (.*);
`default_nettype wire

// *** tb/pdm_irq_src.sv ***
`timescale 1ns/1ns
`default_nettype none
// ------------------------------
// Interrupt source beside the core
// ------------------------------
module pdm_irq_src (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic raise,
  input wire logic irq_exc_start,
  output logic irq_pending
);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) irq_pending <= 1'b0;
    else if (irq_exc_start) irq_pending <= 1'b0;
    else if (raise) irq_pending <= 1'b1;
  end
endmodule
`default_nettype wire

// *** tb/pdm_power_down_ctrl_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
// ------------------------------
// Bench for the power-down control
// ------------------------------
module pdm_power_down_ctrl_bench;
  import pdm_pkg::*;
  localparam logic [31:0] A = PDM_STBY_CTRL_ADDR;
  logic ref_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, sleep_exec = 1'b0;
  logic [31:0] reg_addr = A;
  logic [7:0] reg_wdata = 8'h1f, reg_rdata;
  logic watchdog_run_enable = 1'b0, raise = 1'b0, irq_pending, irq_src_enabled = 1'b1, xfer_addr_err = 1'b0;
  logic power_on_reset_n = 1'b1, manual_reset_n = 1'b1, cpu_halt, periph_clk_en, sys_clk_run;
  logic irq_exc_start, addr_err_exc_start, manual_reset_req, periph_standby_init, port_hold, port_float;
  logic [3:0] irq_level = 4'h2, cpu_mask_level = 4'h2;
  logic [1:0] pd_mode;
  int fail_count = 0, n_compared = 0;
  pdm_power_down_ctrl pdm_power_down_ctrl_i (.*);
  pdm_irq_src pdm_irq_src_i (.*);
  initial forever #20 ref_clk = ~ref_clk;
  task automatic tick(int n = 1);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(logic [7:0] d);
    tick;
    reg_wr <= 1'b1;
    reg_addr <= A;
    reg_wdata <= d;
    tick;
    reg_wr <= 1'b0;
  endtask
  // Read data only stand in the cycle after the strobe
  task automatic rd(logic [31:0] a, logic [7:0] exp);
    tick;
    reg_rd <= 1'b1;
    reg_addr <= a;
    tick;
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk(reg_rdata, exp);
  endtask
  task automatic sleep;
    tick;
    sleep_exec <= 1'b1;
    tick;
    sleep_exec <= 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic end_of_test;
    $display("compared %0d, unexpected %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Whole run is about 120 cycles; this is ample
  initial begin
    #100000;
    fail_count++;
    end_of_test;
  end
  initial begin
    tick(2);
    rst <= 1'b0;
    rd(A, PDM_STBY_CTRL_RESET);
    rd(A + 32'h4, PDM_UNMAPPED_READ);
    tick;
    watchdog_run_enable <= 1'b1;
    wr(8'hdf);
    rd(A, 8'h1f);
    tick;
    watchdog_run_enable <= 1'b0;
    wr(8'h9f);
    rd(A, 8'h9f);
    tick;
    watchdog_run_enable <= 1'b1;
    wr(8'h1f);
    rd(A, 8'h1f);
    $display("test register done");
    // Masked, then disabled, then accepted interrupt
    sleep;
    chk(pd_mode, PDM_SLEEP);
    chk(cpu_halt & sys_clk_run & periph_clk_en, 1'b1);
    tick;
    raise <= 1'b1;
    tick;
    raise <= 1'b0;
    tick(3);
    @(negedge ref_clk);
    chk(pd_mode, PDM_SLEEP);
    tick;
    irq_src_enabled <= 1'b0;
    irq_level <= 4'h5;
    tick(3);
    @(negedge ref_clk);
    chk(pd_mode, PDM_SLEEP);
    tick;
    irq_src_enabled <= 1'b1;
    tick;
    @(negedge ref_clk);
    chk({irq_exc_start, pd_mode}, {1'b1, PDM_RUN});
    $display("test interrupt done");
    // Address error, manual reset, power-on reset out of sleep
    for (int c = 1; c < 4; c++) begin
      sleep;
      chk(pd_mode, PDM_SLEEP);
      tick;
      xfer_addr_err <= (c == 1);
      manual_reset_n <= (c != 2);
      power_on_reset_n <= (c != 3);
      tick;
      @(negedge ref_clk);
      if (c == 1) chk(addr_err_exc_start, 1'b1);
      tick(4);
      @(negedge ref_clk);
      if (c == 2) chk(manual_reset_req, 1'b1);
      chk(pd_mode, PDM_RUN);
      tick;
      xfer_addr_err <= 1'b0;
      manual_reset_n <= 1'b1;
      power_on_reset_n <= 1'b1;
      tick(4);
    end
    $display("test wake done");
    // Standby with ports held, then floating
    for (int f = 0; f < 2; f++) begin
      tick;
      watchdog_run_enable <= 1'b0;
      wr({1'b1, f[0], 6'h1f});
      sleep;
      chk({periph_standby_init, pd_mode}, {1'b1, PDM_STANDBY});
      chk({sys_clk_run, periph_clk_en, port_hold, port_float}, {2'b00, !f[0], f[0]});
      tick;
      xfer_addr_err <= 1'b1;
      manual_reset_n <= 1'b0;
      tick(6);
      @(negedge ref_clk);
      chk(pd_mode, PDM_STANDBY);
      tick;
      xfer_addr_err <= 1'b0;
      manual_reset_n <= 1'b1;
      power_on_reset_n <= 1'b0;
      tick(5);
      @(negedge ref_clk);
      chk(pd_mode, PDM_RUN);
      tick;
      power_on_reset_n <= 1'b1;
      tick(3);
      rd(A, 8'h1f);
    end
    $display("test standby done");
    end_of_test;
  end
endmodule
`default_nettype wire
